// ===== logic/pcs_pkg.sv
package pcs_pkg;

  // ----------------------------------------------------------------
  // Variants, widths and reset values
  // ----------------------------------------------------------------
  localparam int VARIANT_2K = 0;
  localparam int VARIANT_4K = 1;
  localparam int VARIANT_6K = 2;
  localparam int VARIANT_8K = 3;
  localparam int TARGET_W = 13;
  localparam int SLOT_COUNT = 5;
  localparam int SAVE_COUNT = 3;
  localparam int SAVE_W_MAX = 6;
  localparam int SP_W = 3;
  localparam logic [SP_W-1:0] SP_EMPTY = 3'h5;
  localparam logic [SP_W-1:0] SP_FAULT_MIN = 3'h6;
  localparam logic [TARGET_W-1:0] PC_RESET = 13'h0000;
  localparam logic [TARGET_W-1:0] CALL_REACH_MAX = 13'h07FF;
  localparam logic [1:0] SAVE_CNT_FULL = 2'h3;

  // ----------------------------------------------------------------
  // Sequencer commands
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    CMD_NOP = 4'b0000,
    CMD_STEP = 4'b0001,
    CMD_DIRECT_BRANCH = 4'b0010,
    CMD_INDIRECT_BRANCH = 4'b0011,
    CMD_DIRECT_CALL = 4'b0100,
    CMD_INDIRECT_CALL = 4'b0101,
    CMD_TABLE_FIRST = 4'b0110,
    CMD_TABLE_SECOND = 4'b0111,
    CMD_PUSH_POINTER = 4'b1000,
    CMD_POP_POINTER = 4'b1001,
    CMD_RETURN = 4'b1010,
    CMD_RETURN_SKIP = 4'b1011,
    CMD_INT_ACCEPT = 4'b1100,
    CMD_INT_RETURN = 4'b1101
  } pcs_cmd_type;

  // ----------------------------------------------------------------
  // Width per variant
  // ----------------------------------------------------------------
  function automatic int pc_width(input int variant);
    if (variant == VARIANT_2K) begin
      return 11;
    end else if (variant == VARIANT_4K) begin
      return 12;
    end
    return 13;
  endfunction : pc_width

  function automatic int save_width(input int variant);
    if (variant >= VARIANT_6K) begin
      return 6;
    end
    return 5;
  endfunction : save_width

endpackage : pcs_pkg

// ===== logic/pcs_stack_if.sv
`timescale 1ns/1ps
`default_nettype none

interface pcs_stack_if #(
  parameter int WIDTH = 13
);
  logic write_en;
  logic [pcs_pkg::SP_W-1:0] write_addr;
  logic [WIDTH-1:0] write_data;
  logic [pcs_pkg::SP_W-1:0] read_addr;
  logic [WIDTH-1:0] read_data;

  modport owner (
    output write_en,
    output write_addr,
    output write_data,
    output read_addr,
    input read_data
  );

  modport memory (
    input write_en,
    input write_addr,
    input write_data,
    input read_addr,
    output read_data
  );
endinterface : pcs_stack_if

`default_nettype wire

// ===== logic/pcs_slot_mem.sv
`timescale 1ns/1ps
`default_nettype none

module pcs_slot_mem #(
  parameter int WIDTH = 13
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  pcs_stack_if.memory port
);

  // ----------------------------------------------------------------
  // Five return address slots
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] slots [pcs_pkg::SLOT_COUNT];
  logic [WIDTH-1:0] next_read_data;

  // A write to the slot being read is passed through, so a return right
  // after a push sees the new address without a wasted cycle.
  always_comb begin
    next_read_data = '0;
    if (port.write_en && port.write_addr == port.read_addr) begin
      next_read_data = port.write_data;
    end else if (int'(port.read_addr) < pcs_pkg::SLOT_COUNT) begin
      next_read_data = slots[port.read_addr];
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      port.read_data <= '0;
    end else begin
      port.read_data <= next_read_data;
    end
  end

  // Slot contents need no reset; pointers outside the five slots write nothing.
  always_ff @(posedge core_clk) begin
    if (port.write_en && int'(port.write_addr) < pcs_pkg::SLOT_COUNT) begin
      slots[port.write_addr] <= port.write_data;
    end
  end

endmodule : pcs_slot_mem

`default_nettype wire

// ===== logic/pcs_sequencer.sv
`timescale 1ns/1ps
`default_nettype none

module pcs_sequencer #(
  parameter int VARIANT = pcs_pkg::VARIANT_8K
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic reset_in_n,
  input wire logic cmd_valid,
  input wire pcs_pkg::pcs_cmd_type cmd,
  input wire logic [pcs_pkg::TARGET_W-1:0] target_addr,
  input wire logic [pcs_pkg::TARGET_W-1:0] address_pointer_reg,
  input wire logic bank_select,
  input wire logic [4:0] status_word_flags,
  input wire logic [3:0] key_input_group_a,
  input wire logic [3:0] key_input_group_b,
  input wire logic watchdog_overflow,
  input wire logic low_voltage_detect,
  output logic [pcs_pkg::TARGET_W-1:0] program_address_counter,
  output logic [3:0] stack_level_pointer,
  output logic [pcs_pkg::TARGET_W-1:0] popped_pointer,
  output logic restore_valid,
  output logic restore_bank,
  output logic [4:0] restore_flags,
  output logic fault_indicator_out_o,
  output logic fault_indicator_out_oe,
  output logic osc_run,
  output logic standby_release
);

  // ----------------------------------------------------------------
  // Widths and helpers
  // ----------------------------------------------------------------
  localparam int PC_W = pcs_pkg::pc_width(VARIANT);
  localparam int SV_W = pcs_pkg::save_width(VARIANT);

  function automatic logic [PC_W-1:0] to_pc(input logic [pcs_pkg::TARGET_W-1:0] a);
    return a[PC_W-1:0];
  endfunction : to_pc

  function automatic logic [pcs_pkg::TARGET_W-1:0] widen(input logic [PC_W-1:0] a);
    logic [pcs_pkg::TARGET_W-1:0] w;
    w = '0;
    w[PC_W-1:0] = a;
    return w;
  endfunction : widen

  pcs_stack_if #(.WIDTH(PC_W)) stk ();

  pcs_slot_mem #(.WIDTH(PC_W)) u_slots (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .port(stk.memory)
  );

  // ----------------------------------------------------------------
  // Counter and return stack
  // ----------------------------------------------------------------
  logic [PC_W-1:0] pc;
  logic [PC_W-1:0] next_pc;
  logic [pcs_pkg::SP_W-1:0] sp;
  logic [pcs_pkg::SP_W-1:0] next_sp;
  logic [pcs_pkg::TARGET_W-1:0] next_popped;
  logic go;
  logic push;
  logic pop;

  assign go = cmd_valid && reset_in_n;
  assign stk.read_addr = next_sp;
  assign stk.write_en = push;
  assign stk.write_addr = next_sp;

  always_comb begin
    next_pc = pc;
    next_sp = sp;
    next_popped = popped_pointer;
    push = 1'b0;
    pop = 1'b0;
    stk.write_data = pc + 1'b1;
    if (!reset_in_n) begin
      next_pc = '0;
      next_sp = pcs_pkg::SP_EMPTY;
    end else if (go) begin
      case (cmd)
        pcs_pkg::CMD_STEP: begin
          next_pc = pc + 1'b1;
        end
        pcs_pkg::CMD_DIRECT_BRANCH: begin
          next_pc = to_pc(target_addr);
        end
        pcs_pkg::CMD_INDIRECT_BRANCH: begin
          next_pc = to_pc(address_pointer_reg);
        end
        pcs_pkg::CMD_DIRECT_CALL: begin
          push = 1'b1;
          next_pc = to_pc(target_addr & pcs_pkg::CALL_REACH_MAX);
        end
        pcs_pkg::CMD_INDIRECT_CALL, pcs_pkg::CMD_TABLE_FIRST: begin
          push = 1'b1;
          next_pc = to_pc(address_pointer_reg);
        end
        pcs_pkg::CMD_PUSH_POINTER: begin
          push = 1'b1;
          stk.write_data = to_pc(address_pointer_reg);
        end
        pcs_pkg::CMD_INT_ACCEPT: begin
          push = 1'b1;
          stk.write_data = pc;
          next_pc = to_pc(target_addr);
        end
        pcs_pkg::CMD_POP_POINTER: begin
          pop = 1'b1;
          next_popped = widen(stk.read_data);
        end
        pcs_pkg::CMD_RETURN, pcs_pkg::CMD_TABLE_SECOND, pcs_pkg::CMD_INT_RETURN: begin
          pop = 1'b1;
          next_pc = stk.read_data;
        end
        pcs_pkg::CMD_RETURN_SKIP: begin
          pop = 1'b1;
          next_pc = stk.read_data + 1'b1;
        end
        default: begin
          next_pc = pc;
        end
      endcase
      // The pointer wraps in three bits; landing on six or seven is the fault.
      if (push) begin
        next_sp = sp - 1'b1;
      end else if (pop) begin
        next_sp = sp + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pc <= '0;
      sp <= pcs_pkg::SP_EMPTY;
      popped_pointer <= '0;
    end else begin
      pc <= next_pc;
      sp <= next_sp;
      popped_pointer <= next_popped;
    end
  end

  assign program_address_counter = widen(pc);
  assign stack_level_pointer = {1'b0, sp};

  // ----------------------------------------------------------------
  // Interrupt save slots
  // ----------------------------------------------------------------
  logic [SV_W-1:0] saves [pcs_pkg::SAVE_COUNT];
  logic [SV_W-1:0] next_saves [pcs_pkg::SAVE_COUNT];
  logic [1:0] save_cnt;
  logic [1:0] next_save_cnt;
  logic [SV_W-1:0] save_word;
  logic [SV_W-1:0] next_restore;
  logic next_restore_valid;
  logic [5:0] restore_word;

  // Small variants have no bank bit, so the bank field drops out of the word.
  assign save_word = SV_W'({bank_select, status_word_flags});

  always_comb begin
    next_saves = saves;
    next_save_cnt = save_cnt;
    next_restore = restore_word[SV_W-1:0];
    next_restore_valid = 1'b0;
    if (!reset_in_n) begin
      next_save_cnt = '0;
    end else if (go && cmd == pcs_pkg::CMD_INT_ACCEPT) begin
      if (save_cnt == pcs_pkg::SAVE_CNT_FULL) begin
        next_saves[0] = saves[1];
        next_saves[1] = saves[2];
        next_saves[2] = save_word;
      end else begin
        next_saves[save_cnt] = save_word;
        next_save_cnt = save_cnt + 1'b1;
      end
    end else if (go && cmd == pcs_pkg::CMD_INT_RETURN && save_cnt != 2'h0) begin
      next_restore = saves[save_cnt - 1'b1];
      next_restore_valid = 1'b1;
      next_save_cnt = save_cnt - 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      saves <= '{default: '0};
      save_cnt <= '0;
      restore_word <= '0;
      restore_valid <= 1'b0;
    end else begin
      saves <= next_saves;
      save_cnt <= next_save_cnt;
      restore_word <= 6'(next_restore);
      restore_valid <= next_restore_valid;
    end
  end

  assign restore_bank = (SV_W == pcs_pkg::SAVE_W_MAX) ? restore_word[5] : 1'b0;
  assign restore_flags = restore_word[4:0];

  // ----------------------------------------------------------------
  // Fault, oscillator and standby
  // ----------------------------------------------------------------
  logic next_fault;
  logic next_osc;
  logic next_wake;

  always_comb begin
    next_fault = (next_sp >= pcs_pkg::SP_FAULT_MIN) || watchdog_overflow
      || low_voltage_detect;
    next_osc = reset_in_n;
    next_wake = !(&{key_input_group_a, key_input_group_b});
  end

  // The pin only ever sinks; a high level comes from the board pull-up.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fault_indicator_out_oe <= 1'b0;
      osc_run <= 1'b0;
      standby_release <= 1'b0;
    end else begin
      fault_indicator_out_oe <= next_fault;
      osc_run <= next_osc;
      standby_release <= next_wake;
    end
  end

  assign fault_indicator_out_o = 1'b0;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  reset_pc_a: assert property (!reset_in_n |=> pc == '0 && sp == pcs_pkg::SP_EMPTY)
    else $error("counter or pointer not cleared by reset pin");
  sp_msb_a: assert property (stack_level_pointer[3] == 1'b0)
    else $error("pointer top bit set");
  push_dec_a: assert property (push |=> sp == $past(sp) - 3'h1)
    else $error("push did not step pointer down");
  pop_inc_a: assert property (pop |=> sp == $past(sp) + 3'h1)
    else $error("pop did not step pointer up");
  // A call that lands outside the five slots writes nothing, so only in-range calls are held.
  call_return_a: assert property (go && cmd == pcs_pkg::CMD_DIRECT_CALL
    && sp != 3'h0 && sp <= pcs_pkg::SP_EMPTY ##1
    (go && cmd == pcs_pkg::CMD_RETURN) |=> pc == $past(pc, 2) + 1'b1)
    else $error("return did not come back after call");
  call_reach_a: assert property (go && cmd == pcs_pkg::CMD_DIRECT_CALL
    |=> widen(pc) <= pcs_pkg::CALL_REACH_MAX)
    else $error("direct call left lowest block");
  branch_reach_a: assert property (go && cmd == pcs_pkg::CMD_INDIRECT_BRANCH
    |=> pc == to_pc($past(address_pointer_reg)))
    else $error("indirect branch target wrong");
  stack_fault_a: assert property (sp >= pcs_pkg::SP_FAULT_MIN |-> fault_indicator_out_oe)
    else $error("stack fault not shown on fault pin");
  fault_clear_a: assert property (!next_fault |=> !fault_indicator_out_oe)
    else $error("fault pin low without cause");
  osc_stop_a: assert property (!reset_in_n |=> !osc_run)
    else $error("oscillator runs during reset");
  key_wake_a: assert property (!(&{key_input_group_a, key_input_group_b}) |=> standby_release)
    else $error("key line did not release standby");
  save_limit_a: assert property (save_cnt == 2'h3
    && go && cmd == pcs_pkg::CMD_INT_ACCEPT
    |=> save_cnt == 2'h3 && saves[2] == $past(save_word))
    else $error("overflowing interrupt save mishandled");

  nest_cov: cover property (go && cmd == pcs_pkg::CMD_DIRECT_CALL && sp == 3'h0);
  table_cov: cover property (go && cmd == pcs_pkg::CMD_TABLE_FIRST ##1
    go && cmd == pcs_pkg::CMD_TABLE_SECOND);
  int_cov: cover property (restore_valid && save_cnt == 2'h2);
  wake_cov: cover property (standby_release && osc_run);

endmodule : pcs_sequencer

`default_nettype wire

// ===== tb/program_counter_stack_tb.sv
`timescale 1ns/1ps
`default_nettype none

module program_counter_stack_tb;
  typedef struct {int due; int kind; logic [12:0] val;} pcs_note_type;

  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic reset_in_n = 1'b1;
  logic cmd_valid = 1'b0;
  pcs_pkg::pcs_cmd_type cmd = pcs_pkg::CMD_NOP;
  logic [12:0] target_addr = 13'h0000;
  logic [12:0] address_pointer_reg = 13'h0000;
  logic bank_select = 1'b0;
  logic [4:0] status_word_flags = 5'h00;
  logic [3:0] key_input_group_a = 4'hF;
  logic [3:0] key_input_group_b = 4'hF;
  logic watchdog_overflow = 1'b0;
  logic low_voltage_detect = 1'b0;
  logic [12:0] program_address_counter;
  logic [3:0] stack_level_pointer;
  logic [12:0] popped_pointer;
  logic restore_valid;
  logic restore_bank;
  logic [4:0] restore_flags;
  logic fault_indicator_out_o;
  logic fault_indicator_out_oe;
  logic osc_run;
  logic standby_release;

  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0;
  pcs_note_type q[$];
  pcs_note_type nt;
  logic [5:0] rq[$];
  // ----------------------------------------------------------------
  // Reference state of counter and stack
  // ----------------------------------------------------------------
  logic [12:0] m_pc = 13'h0000;
  logic [2:0] m_sp = 3'h5;
  logic [12:0] m_slot [5];
  logic [5:0] m_save [3];
  int m_cnt = 0;
  bit pc_ok = 1'b1;
  bit pop_ok;

  always #12.5 core_clk = ~core_clk;

  pcs_sequencer #(.VARIANT(pcs_pkg::VARIANT_8K)) u_dut (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .reset_in_n(reset_in_n),
    .cmd_valid(cmd_valid),
    .cmd(cmd),
    .target_addr(target_addr),
    .address_pointer_reg(address_pointer_reg),
    .bank_select(bank_select),
    .status_word_flags(status_word_flags),
    .key_input_group_a(key_input_group_a),
    .key_input_group_b(key_input_group_b),
    .watchdog_overflow(watchdog_overflow),
    .low_voltage_detect(low_voltage_detect),
    .program_address_counter(program_address_counter),
    .stack_level_pointer(stack_level_pointer),
    .popped_pointer(popped_pointer),
    .restore_valid(restore_valid),
    .restore_bank(restore_bank),
    .restore_flags(restore_flags),
    .fault_indicator_out_o(fault_indicator_out_o),
    .fault_indicator_out_oe(fault_indicator_out_oe),
    .osc_run(osc_run),
    .standby_release(standby_release)
  );

  // ----------------------------------------------------------------
  // Comparison and reporting
  // ----------------------------------------------------------------
  task automatic tally(input bit ok, input logic [12:0] e, input logic [12:0] g);
    comparisons++;
    if (!ok) begin
      n_fail++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : tally

  task automatic cmp_addr(input logic [12:0] e, input logic [12:0] g);
    tally(g === e, e, g);
  endtask : cmp_addr

  task automatic cmp_bit(input logic e, input logic g);
    tally(g === e, {12'h000, e}, {12'h000, g});
  endtask : cmp_bit

  task automatic cmp_word(input logic [5:0] e, input logic [5:0] g);
    tally(g === e, {7'h00, e}, {7'h00, g});
  endtask : cmp_word

  task automatic end_of_test;
    if (q.size() != 0 || rq.size() != 0) begin
      n_fail++;
    end
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test

  task automatic note(input int kind, input logic [12:0] v, input int lag);
    q.push_back('{cyc + lag, kind, v});
  endtask : note

  // ----------------------------------------------------------------
  // Stimulus helpers
  // ----------------------------------------------------------------
  task automatic push(input logic [12:0] v);
    m_sp = m_sp - 3'h1;
    if (m_sp < 3'h5) begin
      m_slot[m_sp] = v;
    end
  endtask : push

  task automatic pop(output logic [12:0] v);
    pop_ok = (m_sp < 3'h5);
    v = pop_ok ? m_slot[m_sp] : 13'h0000;
    pc_ok = pc_ok & pop_ok;
    m_sp = m_sp + 3'h1;
  endtask : pop

  task automatic run(input pcs_pkg::pcs_cmd_type c, input logic [12:0] tgt,
                     input logic [12:0] ptr);
    logic [12:0] v;
    @(negedge core_clk);
    cmd_valid = 1'b1;
    cmd = c;
    target_addr = tgt;
    address_pointer_reg = ptr;
    bank_select = 1'($urandom());
    status_word_flags = 5'($urandom());
    v = m_pc + 13'h0001;
    pop_ok = 1'b0;
    case (c)
      pcs_pkg::CMD_STEP: m_pc = v;
      pcs_pkg::CMD_DIRECT_BRANCH: begin
        m_pc = tgt;
        pc_ok = 1'b1;
      end
      pcs_pkg::CMD_INDIRECT_BRANCH: m_pc = ptr;
      pcs_pkg::CMD_DIRECT_CALL: begin
        push(v);
        m_pc = tgt & pcs_pkg::CALL_REACH_MAX;
      end
      pcs_pkg::CMD_INDIRECT_CALL, pcs_pkg::CMD_TABLE_FIRST: begin
        push(v);
        m_pc = ptr;
      end
      pcs_pkg::CMD_RETURN_SKIP: begin
        pop(m_pc);
        m_pc = m_pc + 13'h0001;
      end
      pcs_pkg::CMD_PUSH_POINTER: begin
        push(ptr);
      end
      pcs_pkg::CMD_POP_POINTER: begin
        pop(v);
      end
      pcs_pkg::CMD_INT_ACCEPT: begin
        push(m_pc);
        m_pc = tgt;
        if (m_cnt == 3) begin
          m_save[0] = m_save[1];
          m_save[1] = m_save[2];
          m_cnt = 2;
        end
        m_save[m_cnt] = {bank_select, status_word_flags};
        m_cnt++;
      end
      pcs_pkg::CMD_INT_RETURN: begin
        pop(m_pc);
        if (m_cnt > 0) begin
          m_cnt--;
          rq.push_back(m_save[m_cnt]);
        end
      end
      default: pop(m_pc);
    endcase
    if (pc_ok) begin
      note(0, m_pc, 1);
    end
    note(1, {10'h000, m_sp}, 1);
    note(3, {12'h000, m_sp >= 3'h6}, 1);
    if (c == pcs_pkg::CMD_POP_POINTER && pop_ok) begin
      note(2, v, 2);
    end
  endtask : run

  task automatic idle;
    @(negedge core_clk);
    cmd_valid = 1'b0;
  endtask : idle

  // ----------------------------------------------------------------
  // Result watcher
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
  end

  always @(posedge core_clk) begin
    #1;
    while (q.size() > 0 && q[0].due <= cyc) begin
      nt = q.pop_front();
      case (nt.kind)
        0: cmp_addr(nt.val, program_address_counter);
        1: cmp_addr(nt.val, {9'h000, stack_level_pointer});
        2: cmp_addr(nt.val, popped_pointer);
        3: begin
          cmp_bit(nt.val[0], fault_indicator_out_oe);
          cmp_bit(1'b0, fault_indicator_out_o);
        end
        4: cmp_bit(nt.val[0], osc_run);
        default: cmp_bit(nt.val[0], standby_release);
      endcase
    end
    if (restore_valid === 1'b1) begin
      if (rq.size() == 0) begin
        cmp_bit(1'b0, restore_valid);
      end else begin
        cmp_word(rq.pop_front(), {restore_bank, restore_flags});
      end
    end
  end

  // A hang is cut short here; the limit sits far above the scripted run.
  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h5978));
    repeat (16) @(posedge core_clk);
    @(negedge core_clk);
    note(0, 13'h0000, 1);
    note(1, 13'h0005, 1);
    sys_rst = 1'b0;
    note(4, 13'h0001, 1);
    run(pcs_pkg::CMD_DIRECT_BRANCH, 13'h1FFF, 13'h0000);
    run(pcs_pkg::CMD_STEP, 13'h0000, 13'h0000);
    run(pcs_pkg::CMD_INDIRECT_BRANCH, 13'h0000, 13'h1ABC);
    run(pcs_pkg::CMD_TABLE_FIRST, 13'h0000, 13'($urandom()));
    run(pcs_pkg::CMD_TABLE_SECOND, 13'h0000, 13'h0000);
    for (int i = 0; i < 5; i++) begin
      run(pcs_pkg::CMD_DIRECT_CALL, 13'($urandom()) | 13'h1800, 13'h0000);
    end
    run(pcs_pkg::CMD_RETURN_SKIP, 13'h0000, 13'h0000);
    for (int i = 0; i < 4; i++) begin
      run(pcs_pkg::CMD_RETURN, 13'h0000, 13'h0000);
    end
    run(pcs_pkg::CMD_DIRECT_CALL, 13'($urandom()), 13'h0000);
    run(pcs_pkg::CMD_RETURN, 13'h0000, 13'h0000);
    for (int i = 0; i < 6; i++) begin
      run(pcs_pkg::CMD_INDIRECT_CALL, 13'h0000, 13'($urandom()));
    end
    // Commands offered while the reset pin is low must leave no trace.
    @(negedge core_clk);
    reset_in_n = 1'b0;
    cmd = pcs_pkg::CMD_DIRECT_BRANCH;
    target_addr = 13'h0AAA;
    m_pc = 13'h0000;
    m_sp = 3'h5;
    m_cnt = 0;
    pc_ok = 1'b1;
    for (int i = 1; i < 4; i++) begin
      note(0, 13'h0000, i);
      note(1, 13'h0005, i);
      note(4, 13'h0000, i);
    end
    repeat (3) @(negedge core_clk);
    reset_in_n = 1'b1;
    cmd_valid = 1'b0;
    note(4, 13'h0001, 1);
    run(pcs_pkg::CMD_PUSH_POINTER, 13'h0000, 13'($urandom()));
    idle();
    run(pcs_pkg::CMD_POP_POINTER, 13'h0000, 13'h0000);
    idle();
    run(pcs_pkg::CMD_DIRECT_BRANCH, 13'h0100, 13'h0000);
    run(pcs_pkg::CMD_RETURN, 13'h0000, 13'h0000);
    run(pcs_pkg::CMD_PUSH_POINTER, 13'h0000, 13'h0123);
    run(pcs_pkg::CMD_DIRECT_BRANCH, 13'h0200, 13'h0000);
    for (int i = 0; i < 4; i++) begin
      run(pcs_pkg::CMD_INT_ACCEPT, 13'($urandom()), 13'h0000);
    end
    for (int i = 0; i < 5; i++) begin
      run(pcs_pkg::CMD_INT_RETURN, 13'h0000, 13'h0000);
    end
    // The pointer is brought back from underflow so the input faults stand alone.
    run(pcs_pkg::CMD_PUSH_POINTER, 13'h0000, 13'h0000);
    idle();
    watchdog_overflow = 1'b1;
    note(3, 13'h0001, 1);
    @(negedge core_clk);
    watchdog_overflow = 1'b0;
    low_voltage_detect = 1'b1;
    note(3, 13'h0001, 1);
    @(negedge core_clk);
    low_voltage_detect = 1'b0;
    note(3, 13'h0000, 1);
    for (int i = 0; i < 9; i++) begin
      @(negedge core_clk);
      {key_input_group_b, key_input_group_a} = ~(8'h01 << i);
      note(5, {12'h000, i < 8}, 1);
    end
    repeat (3) @(negedge core_clk);
    end_of_test();
  end
endmodule : program_counter_stack_tb

`default_nettype wire
